// ===== rtl/tcg_pkg.sv
// tcg_pkg: constants, types and helpers of the time code generator
// assumes a 125 MHz pclk and binary hh:mm:ss:ff fields
package tcg_pkg;
    // clock and hold-off step timing
    localparam int unsigned CLK_NS = 8;
    localparam int unsigned HOLDOFF_STEP_NS = 100_000_000;
    localparam logic [6:0] HOLDOFF_MAX = 7'h50; // 8.0 s in tenths
    localparam logic [6:0] HOLDOFF_RST = 7'h14; // 2.0 s in tenths
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_HOLD = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_UVAL = 8'h0c;
    localparam logic [7:0] OFS_UBITS = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    localparam logic [7:0] OFS_GEN = 8'h18;
    localparam logic [7:0] OFS_RX = 8'h1c;
    localparam logic [7:0] OFS_STAMP = 8'h20;
    // field positions
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_RATE_LSB = 4;
    localparam int CTL_DROP = 6;
    localparam int CTL_PRE = 7;
    localparam int CTL_UBF_LSB = 8;
    localparam int CMD_RX = 0;
    localparam int CMD_CLR = 1;
    localparam int CMD_USER = 2;
    localparam int ST_LOCK = 3;
    localparam logic [2:0] UBF_LAST = 3'h6;
    localparam logic [2:0] UBF_LOCK_FIRST = 3'h4;
    localparam logic [31:0] RX_DASHES = 32'hffff_ffff;
    // counting limits
    localparam logic [4:0] HH_MAX = 5'h17;
    localparam logic [5:0] MS_MAX = 6'h3b;
    localparam logic [5:0] TEN_MIN = 6'h0a;
    localparam logic [4:0] DROP_SKIP = 5'h02;

    typedef enum logic [3:0] {
        M_OFF, M_CONTINUOUS_COUNT, M_RECORD_GATED_COUNT, M_SINGLE_REJAM_ON_CONNECT, M_DAILY_CLOCK_SEED,
        M_FOLLOW_EXTERNAL_CODE, M_FOLLOW_WITH_FLYWHEEL, M_EXTERNAL_TRIGGERED_CAPTURE, M_FLYWHEEL_TRIGGERED_CAPTURE
    } tcg_mode_t;
    typedef enum logic [1:0] {RATE_24, RATE_25, RATE_30} tcg_rate_t;
    typedef enum logic [1:0] {CAP_IDLE, CAP_PENDING, CAP_RECORDING} tcg_cap_t;
    typedef struct packed {
        logic [4:0] hh;
        logic [5:0] mm;
        logic [5:0] ss;
        logic [4:0] ff;
    } tcg_tc_t;
    typedef struct packed {
        tcg_mode_t mode;
        tcg_rate_t rate;
        logic drop;
        logic pre;
        logic [2:0] ubf;
        logic [6:0] hold;
        tcg_tc_t uval;
        logic [31:0] ubits;
        tcg_tc_t gen;
        tcg_tc_t last_rx;
        logic armed;
        logic p_rx;
        logic p_clr;
        logic p_user;
        logic p_tod;
        logic lock;
        tcg_cap_t cap;
        logic [23:0] presc;
        logic [6:0] tent;
        logic fopen;
        tcg_tc_t stamp;
        logic [31:0] rdata;
        logic serr;
    } tcg_st_t;
    localparam tcg_st_t ST_RST = '{mode: M_RECORD_GATED_COUNT, rate: RATE_30, hold: HOLDOFF_RST, armed: 1'b1,
        p_tod: 1'b1, cap: CAP_IDLE, default: '0};

    // highest frame number of a rate
    function automatic logic [4:0] frame_max(tcg_rate_t r);
        case (r)
            RATE_24: return 5'h17;
            RATE_25: return 5'h18;
            default: return 5'h1d;
        endcase
    endfunction

    // time code laid out one pair per byte
    function automatic logic [31:0] tc_word(tcg_tc_t t);
        return {3'h0, t.hh, 2'h0, t.mm, 2'h0, t.ss, 3'h0, t.ff};
    endfunction

    function automatic tcg_tc_t word_tc(logic [31:0] w);
        return '{hh: w[28:24], mm: w[21:16], ss: w[13:8], ff: w[4:0]};
    endfunction

    // legal code up to 23:59:59 and the last frame of the rate
    function automatic logic tc_ok(logic [31:0] w, tcg_rate_t r);
        return w[28:24] <= HH_MAX && w[21:16] <= MS_MAX && w[13:8] <= MS_MAX && w[4:0] <= frame_max(r)
            && w[31:29] == 3'h0 && w[23:22] == 2'h0 && w[15:14] == 2'h0 && w[7:5] == 3'h0;
    endfunction

    // one frame forward, skipping frames 00 and 01 of non-tenth minutes in skip mode
    function automatic tcg_tc_t tc_next(tcg_tc_t t, tcg_rate_t r, logic df);
        tcg_tc_t n;
        n = t;
        if (t.ff >= frame_max(r)) begin
            n.ff = 5'h00;
            if (t.ss >= MS_MAX) begin
                n.ss = 6'h00;
                if (t.mm >= MS_MAX) begin
                    n.mm = 6'h00;
                    n.hh = (t.hh >= HH_MAX) ? 5'h00 : t.hh + 5'h01;
                end else begin
                    n.mm = t.mm + 6'h01;
                end
                if (df && (n.mm % TEN_MIN) != 6'h00) begin
                    n.ff = DROP_SKIP;
                end
            end else begin
                n.ss = t.ss + 6'h01;
            end
        end else begin
            n.ff = t.ff + 5'h01;
        end
        return n;
    endfunction
endpackage

// ===== rtl/tcg_core.sv
// tcg_core: time code generator, mode control and auto-record gating
// assumes frame_tick is a one-cycle pulse per frame of the internal reference,
// rx_* come from a time code reader in the pclk domain, registers over APB
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module tcg_core #(
    parameter int unsigned TENTH_CYCLES = tcg_pkg::HOLDOFF_STEP_NS / tcg_pkg::CLK_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_tick,
    input wire logic record_active,
    input wire logic rx_strobe,
    input wire logic rx_valid,
    input wire tcg_pkg::tcg_rate_t rx_rate,
    input wire tcg_pkg::tcg_tc_t rx_tc,
    input wire tcg_pkg::tcg_tc_t tod_value,
    input wire logic tod_reset,
    output tcg_pkg::tcg_tc_t gen_tc,
    output logic gen_blank,
    output logic rx_code_valid,
    output logic rec_request,
    output logic rec_pending,
    output logic preroll_capture,
    output logic file_open,
    output tcg_pkg::tcg_tc_t file_stamp,
    output tcg_pkg::tcg_rate_t file_rate,
    output logic file_drop,
    output logic [31:0] user_bits,
    output logic user_field_locked
);
    import tcg_pkg::*;

    tcg_st_t s_r;
    tcg_st_t s_nxt;
    logic setup;
    logic wr;
    logic rx_adv;
    logic rx_still;
    logic rx_load_ok;
    logic auto_md;
    logic fly_md;
    logic follow_md;
    logic adv;
    logic [31:0] wmerge;
    logic werr;
    logic [31:0] rd;

    // bus phases, constant ready, and read data and error from state
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = s_r.rdata;
    assign pslverr = s_r.serr;

    // received code classification
    assign rx_adv = rx_strobe && rx_valid && (rx_tc != s_r.last_rx);
    assign rx_still = rx_strobe && rx_valid && (rx_tc == s_r.last_rx);
    assign rx_load_ok = rx_strobe && rx_valid && (rx_rate == s_r.rate || rx_tc.ff == 5'h00);
    assign auto_md = s_r.mode == M_EXTERNAL_TRIGGERED_CAPTURE || s_r.mode == M_FLYWHEEL_TRIGGERED_CAPTURE;
    assign fly_md = s_r.mode == M_FOLLOW_WITH_FLYWHEEL || s_r.mode == M_FLYWHEEL_TRIGGERED_CAPTURE;
    assign follow_md = auto_md || fly_md || s_r.mode == M_FOLLOW_EXTERNAL_CODE;

    // outputs straight from state, rx_code_valid straight from rx_valid
    assign gen_tc = s_r.gen;
    assign gen_blank = s_r.mode == M_OFF;
    assign rx_code_valid = rx_valid;
    assign rec_request = s_r.cap == CAP_RECORDING;
    assign rec_pending = s_r.cap == CAP_PENDING;
    assign preroll_capture = s_r.pre && s_r.mode != M_RECORD_GATED_COUNT && (!auto_md || s_r.cap != CAP_IDLE);
    assign file_open = s_r.fopen;
    assign file_stamp = s_r.stamp;
    assign file_rate = s_r.rate;
    assign file_drop = s_r.drop;
    assign user_bits = s_r.ubits;
    assign user_field_locked = s_r.lock;

    // register decode: merged write value, refusal and read value
    always_comb begin
        logic [31:0] old;
        old = 32'h0;
        werr = 1'b0;
        rd = 32'h0;
        case (paddr)
            OFS_CTRL: old = {21'h0, s_r.ubf, s_r.pre, s_r.drop, s_r.rate, s_r.mode};
            OFS_HOLD: old = {25'h0, s_r.hold};
            OFS_UVAL: old = tc_word(s_r.uval);
            OFS_UBITS: old = s_r.ubits;
            default: old = 32'h0;
        endcase
        for (int b = 0; b < 4; b++) begin
            wmerge[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : old[b*8 +: 8];
        end
        case (paddr)
            OFS_CTRL: begin
                rd = old;
                werr = wmerge[CTL_MODE_LSB +: 4] > 4'(M_FLYWHEEL_TRIGGERED_CAPTURE)
                    || wmerge[CTL_RATE_LSB +: 2] > 2'(RATE_30) || wmerge[CTL_UBF_LSB +: 3] > UBF_LAST;
            end
            OFS_HOLD: begin
                rd = old;
                werr = wmerge[6:0] > HOLDOFF_MAX;
            end
            OFS_CMD: rd = {29'h0, s_r.p_user, s_r.p_clr, s_r.p_rx};
            OFS_UVAL: begin
                rd = old;
                werr = !tc_ok(wmerge, s_r.rate);
            end
            OFS_UBITS: begin
                rd = old;
                werr = s_r.ubf >= UBF_LOCK_FIRST;
            end
            OFS_STAT: rd = {27'h0, s_r.mode == M_OFF, s_r.lock, rx_valid, rec_pending, rec_request};
            OFS_GEN: rd = tc_word(s_r.gen);
            OFS_RX: rd = rx_valid ? tc_word(rx_tc) : RX_DASHES;
            OFS_STAMP: rd = tc_word(s_r.stamp);
            default: werr = 1'b1;
        endcase
        if (!pwrite && paddr > OFS_STAMP) begin
            werr = 1'b1;
        end else if (!pwrite) begin
            werr = 1'b0;
        end
    end

    // next state: bus writes, pending loads, generator and capture control
    always_comb begin
        s_nxt = s_r;
        s_nxt.fopen = 1'b0;
        adv = 1'b0;
        if (setup) begin
            s_nxt.rdata = rd;
            s_nxt.serr = werr;
        end
        // generator advance per mode
        case (s_r.mode)
            M_OFF: adv = 1'b0;
            M_CONTINUOUS_COUNT, M_SINGLE_REJAM_ON_CONNECT, M_DAILY_CLOCK_SEED: adv = frame_tick;
            M_RECORD_GATED_COUNT: adv = frame_tick && record_active;
            // valid code is followed at its strobes; own count runs at a differing rate outside an idle capture mode, or on loss in the flywheel modes only
            default: adv = frame_tick && (rx_valid ? !rx_load_ok && rx_rate != s_r.rate
                && !(auto_md && s_r.cap == CAP_IDLE) : fly_md);
        endcase
        if (s_r.mode == M_OFF) begin
            s_nxt.gen = s_r.gen;
        end else if (frame_tick && s_r.p_clr) begin
            s_nxt.gen = '0;
            s_nxt.p_clr = 1'b0;
        end else if (frame_tick && s_r.p_user) begin
            s_nxt.gen = s_r.uval;
            s_nxt.p_user = 1'b0;
        end else if (frame_tick && s_r.p_tod && s_r.mode == M_DAILY_CLOCK_SEED) begin
            s_nxt.gen = tod_value;
            s_nxt.p_tod = 1'b0;
        end else if (s_r.p_rx && rx_load_ok) begin
            s_nxt.gen = rx_tc;
            s_nxt.p_rx = 1'b0;
        end else if (s_r.mode == M_SINGLE_REJAM_ON_CONNECT && s_r.armed && rx_adv && rx_load_ok) begin
            s_nxt.gen = rx_tc;
            s_nxt.armed = 1'b0;
        end else if (follow_md && rx_load_ok) begin
            s_nxt.gen = rx_tc;
        end else if (adv) begin
            s_nxt.gen = tc_next(s_r.gen, s_r.rate, s_r.drop);
        end
        if (!rx_valid) begin
            s_nxt.armed = 1'b1;
        end
        if (rx_strobe && rx_valid) begin
            s_nxt.last_rx = rx_tc;
        end
        if (tod_reset) begin
            s_nxt.p_tod = 1'b1;
        end
        // capture sequencing with hold-off
        case (s_r.cap)
            CAP_IDLE: begin
                if (auto_md && rx_adv) begin
                    s_nxt.cap = CAP_PENDING;
                    s_nxt.presc = '0;
                    s_nxt.tent = '0;
                end
            end
            CAP_PENDING: begin
                if (rx_still || !rx_valid) begin
                    s_nxt.cap = CAP_IDLE;
                end else if (s_r.tent >= s_r.hold) begin
                    s_nxt.cap = CAP_RECORDING;
                    s_nxt.fopen = 1'b1;
                    s_nxt.stamp = '{hh: s_r.gen.hh, mm: s_r.gen.mm, ss: s_r.gen.ss,
                        ff: s_r.drop ? DROP_SKIP : 5'h00};
                end else if (s_r.presc == 24'(TENTH_CYCLES - 1)) begin
                    s_nxt.presc = '0;
                    s_nxt.tent = s_r.tent + 7'h01;
                end else begin
                    s_nxt.presc = s_r.presc + 24'h1;
                end
            end
            CAP_RECORDING: begin
                if (rx_still || (!rx_valid && !fly_md)) begin
                    s_nxt.cap = CAP_IDLE;
                end
            end
            default: s_nxt.cap = CAP_IDLE;
        endcase
        if (!auto_md) begin
            s_nxt.cap = CAP_IDLE;
        end
        // register writes at the access edge, set wins over apply
        if (wr && !werr) begin
            case (paddr)
                OFS_CTRL: begin
                    s_nxt.mode = tcg_mode_t'(wmerge[CTL_MODE_LSB +: 4]);
                    s_nxt.rate = tcg_rate_t'(wmerge[CTL_RATE_LSB +: 2]);
                    s_nxt.drop = wmerge[CTL_DROP];
                    s_nxt.pre = wmerge[CTL_PRE];
                    s_nxt.ubf = wmerge[CTL_UBF_LSB +: 3];
                end
                OFS_HOLD: s_nxt.hold = wmerge[6:0];
                OFS_CMD: begin
                    s_nxt.p_rx = s_nxt.p_rx || (pstrb[0] && pwdata[CMD_RX]);
                    s_nxt.p_clr = s_nxt.p_clr || (pstrb[0] && pwdata[CMD_CLR]);
                    s_nxt.p_user = s_nxt.p_user || (pstrb[0] && pwdata[CMD_USER]);
                end
                OFS_UVAL: s_nxt.uval = word_tc(wmerge);
                OFS_UBITS: s_nxt.ubits = wmerge;
                OFS_STAT: begin
                    if (pstrb[0] && pwdata[ST_LOCK]) begin
                        s_nxt.lock = 1'b0;
                    end
                end
                default: s_nxt.lock = s_nxt.lock;
            endcase
        end
        if (wr && paddr == OFS_UBITS && werr) begin
            s_nxt.lock = 1'b1;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_off_hold;
        s_r.mode == M_OFF && !wr |=> $stable(s_r.gen) && gen_blank;
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("generator moved while off");

    property p_cont_adv;
        s_r.mode == M_CONTINUOUS_COUNT && frame_tick && !s_r.p_clr && !s_r.p_user && !wr
            && !(s_r.p_rx && rx_load_ok)
            |=> s_r.gen == tc_next($past(s_r.gen), s_r.rate, s_r.drop);
    endproperty
    a_cont_adv: assert property (p_cont_adv) else $error("continuous count missed a frame");

    property p_gated_hold;
        s_r.mode == M_RECORD_GATED_COUNT && !record_active && !s_r.p_clr && !s_r.p_user && !wr
            && !(s_r.p_rx && rx_load_ok) |=> $stable(s_r.gen);
    endproperty
    a_gated_hold: assert property (p_gated_hold) else $error("gated count moved while not recording");

    property p_follow;
        s_r.mode == M_FOLLOW_EXTERNAL_CODE && rx_strobe && rx_valid && rx_rate == s_r.rate
            && !(frame_tick && (s_r.p_clr || s_r.p_user)) |=> s_r.gen == $past(rx_tc);
    endproperty
    a_follow: assert property (p_follow) else $error("generator did not follow received code");

    property p_pend_first;
        auto_md && s_r.cap == CAP_IDLE && rx_adv && !wr |=> rec_pending && !rec_request;
    endproperty
    a_pend_first: assert property (p_pend_first) else $error("detection did not enter pending");

    property p_still_stop;
        auto_md && rx_still && !wr |=> !rec_request && !rec_pending;
    endproperty
    a_still_stop: assert property (p_still_stop) else $error("stationary code did not stop capture");

    property p_no_holdoff;
        !auto_md ##1 !auto_md |-> !rec_request && !rec_pending;
    endproperty
    a_no_holdoff: assert property (p_no_holdoff) else $error("capture active outside capture modes");

    property p_clear;
        s_r.mode != M_OFF && frame_tick && s_r.p_clr && !wr |=> s_r.gen == '0 && !s_r.p_clr;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero the generator");

    property p_drop;
        s_r.mode == M_CONTINUOUS_COUNT && s_r.drop && frame_tick && !s_r.p_clr && !s_r.p_user && !wr
            && s_r.gen.ss == MS_MAX && s_r.gen.ff == frame_max(s_r.rate) && s_r.gen.mm % TEN_MIN != 6'h09
            && !(s_r.p_rx && rx_load_ok)
            |=> s_r.gen.ff == DROP_SKIP;
    endproperty
    a_drop: assert property (p_drop) else $error("skip mode did not drop frames 00 and 01");

    property p_nogated_pre;
        s_r.mode == M_RECORD_GATED_COUNT |-> !preroll_capture;
    endproperty
    a_nogated_pre: assert property (p_nogated_pre) else $error("pre-roll active in gated count");

    property p_stamp;
        file_open |-> file_stamp.ff == (s_r.drop ? DROP_SKIP : 5'h00) && rec_request;
    endproperty
    a_stamp: assert property (p_stamp) else $error("file start frame wrong");

    c_pending: cover property (rec_pending ##1 rec_request);
    c_abort: cover property (rec_pending ##1 !rec_pending && !rec_request);
    c_rejam: cover property (s_r.mode == M_SINGLE_REJAM_ON_CONNECT && s_r.armed ##1 !s_r.armed);
    c_locked: cover property (!user_field_locked ##1 user_field_locked);
endmodule
`default_nettype wire

// ===== verification/tcg_src.sv
// tcg_src: behavioural external time code source facing tcg_core
// assumes the bench paces frames with send and models the cable with present
`timescale 1ns/1ns
`default_nettype none
module tcg_src
    import tcg_pkg::*;
(
    input wire logic pclk,
    input wire logic send,
    input wire logic adv,
    input wire logic present,
    output logic rx_strobe,
    output logic rx_valid,
    output tcg_rate_t rx_rate,
    output tcg_tc_t rx_tc
);
    tcg_tc_t cur;
    tcg_tc_t nc;
    initial begin
        cur = '{hh: 5'h01, mm: 6'h02, ss: 6'h03, ff: 5'h04};
        rx_strobe = 1'b0;
        rx_valid = 1'b0;
        rx_rate = RATE_30;
        rx_tc = '0;
    end
    // one decoded frame per send; a pulled cable leaves a toggling pattern, not the last code
    always @(posedge pclk) begin
        nc = cur;
        if (send && present && adv) begin
            nc.ff = cur.ff + 5'h01;
        end
        cur <= nc;
        rx_strobe <= send && present;
        rx_valid <= present;
        rx_tc <= present ? nc : ~rx_tc;
    end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// tb: self-checking bench for tcg_core with the tcg_src source model
// assumes the hold-off step is shortened to 4 cycles
`timescale 1ns/1ns
`default_nettype none
module tb;
    import tcg_pkg::*;
    localparam int TC = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_tick, record_active, e;
    logic rx_strobe, rx_valid, rx_code_valid, rec_request, rec_pending, preroll_capture, file_open, gen_blank;
    logic lock, send, adv, present;
    logic fdrop;
    logic [3:0] strb;
    logic [31:0] ubits;
    tcg_rate_t frate;
    tcg_tc_t tod;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, seed;
    tcg_rate_t rx_rate;
    tcg_tc_t rx_tc, gen_tc, fs, v;
    tcg_tc_t tab[3] = '{'{0, 0, 59, 29}, '{0, 9, 59, 29}, '{23, 59, 59, 29}};
    int fail_count, n_compared, i, n;
    tcg_core #(.TENTH_CYCLES(TC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_tick(frame_tick), .record_active(record_active), .rx_strobe(rx_strobe),
        .rx_valid(rx_valid), .rx_rate(rx_rate), .rx_tc(rx_tc), .tod_value(tod), .tod_reset(1'b0),
        .gen_tc(gen_tc), .gen_blank(gen_blank), .rx_code_valid(rx_code_valid), .rec_request(rec_request),
        .rec_pending(rec_pending), .preroll_capture(preroll_capture), .file_open(file_open), .file_stamp(fs),
        .file_rate(frate), .file_drop(fdrop), .user_bits(ubits), .user_field_locked(lock));
    tcg_src src_u (.pclk(pclk), .send(send), .adv(adv), .present(present), .rx_strobe(rx_strobe),
        .rx_valid(rx_valid), .rx_rate(rx_rate), .rx_tc(rx_tc));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // expected next frame at 30 fps, with optional frame skipping
    function automatic tcg_tc_t nx(tcg_tc_t t, logic df);
        nx = t;
        nx.ff = t.ff + 5'h01;
        if (t.ff == 5'h1d) begin
            nx.ff = 5'h00;
            nx.ss = (t.ss == 6'h3b) ? 6'h00 : t.ss + 6'h01;
            if (t.ss == 6'h3b) begin
                nx.mm = (t.mm == 6'h3b) ? 6'h00 : t.mm + 6'h01;
                nx.hh = (t.mm != 6'h3b) ? t.hh : (t.hh == 5'h17) ? 5'h00 : t.hh + 5'h01;
                nx.ff = (df && nx.mm % 10 != 0) ? 5'h02 : 5'h00;
            end
        end
    endfunction
    function automatic logic [31:0] w(tcg_tc_t t);
        return {3'h0, t.hh, 2'h0, t.mm, 2'h0, t.ss, 3'h0, t.ff};
    endfunction
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        n_compared++;
        if (g !== x) begin
            fail_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
        end
    endtask
    // one apb transfer, started just after an edge; q and e take the answer
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            fail_count++;
            wrap_up();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle cycle, so a following call never lowers and raises psel in one step
        @(posedge pclk);
    endtask
    task automatic tick();
        frame_tick <= 1'b1;
        @(posedge pclk);
        frame_tick <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic frm(input logic a);
        adv <= a;
        send <= 1'b1;
        @(posedge pclk);
        send <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic cg(input tcg_tc_t x, input string m);
        chk(w(gen_tc), w(x), m);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, frame_tick, record_active, send, adv, present} = '0;
        paddr = '0;
        pwdata = '0;
        seed = 32'h46285dd4;
        strb = 4'hf;
        tod = '{hh: 5'h0c, mm: 6'h22, ss: 6'h2d, ff: 5'h0b};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cg('0, "gen at reset");
        apb(0, OFS_CTRL, 0);
        chk(q & 32'h7ff, 32'h22, "ctrl reset");
        apb(0, OFS_HOLD, 0);
        chk(q, 32'h14, "hold reset");
        $display("test reset done");
        // random start values through the composed value path
        for (i = 0; i < 4; i++) begin
            seed = xs(seed);
            v = '{seed[28:24] % 5'd24, seed[21:16] % 6'd60, seed[13:8] % 6'd60, seed[4:0] % 5'd30};
            apb(1, OFS_UVAL, w(v));
            tick();
            chk(w(gen_tc), (i == 0) ? 32'h0 : w(nx(tab[0], 0)) & 32'h0, "no load yet");
            apb(1, OFS_CMD, 32'h4);
            tick();
            cg(v, "user load");
            record_active <= 1'b1;
            tick();
            cg(nx(v, 0), "gated run");
            record_active <= 1'b0;
            tick();
            cg(nx(v, 0), "gated stop");
            apb(1, OFS_CMD, 32'h2);
            tick();
            cg('0, "clear");
        end
        apb(1, OFS_UVAL, 32'h1800_0000);
        chk(e, 1, "bad value");
        apb(0, 8'h24, 0);
        chk(e, 1, "unmapped");
        apb(1, OFS_HOLD, 32'h51);
        chk(e, 1, "hold range");
        // edit only the frame pair of the composed value
        strb <= 4'h1;
        apb(1, OFS_UVAL, 32'h5);
        strb <= 4'hf;
        apb(0, OFS_UVAL, 0);
        v.ff = 5'h05;
        chk(q, w(v), "pair edit");
        $display("test loads done");
        // skipped frames and wrap in continuous count
        apb(1, OFS_CTRL, 32'h61);
        chk(32'(fdrop), 1, "skip flag");
        for (i = 0; i < 3; i++) begin
            apb(1, OFS_UVAL, w(tab[i]));
            apb(1, OFS_CMD, 32'h4);
            tick();
            tick();
            cg(nx(tab[i], 1), "skip step");
        end
        $display("test skip done");
        // received code: follow, load, absence
        present <= 1'b1;
        apb(1, OFS_CTRL, 32'h25);
        frm(1);
        frm(1);
        cg(rx_tc, "follow");
        apb(1, OFS_CTRL, 32'h15);
        chk(32'(frate), 32'(RATE_25), "file rate");
        apb(1, OFS_CTRL, 32'h21);
        apb(1, OFS_CMD, 32'h1);
        frm(1);
        cg(rx_tc, "load rx");
        v = rx_tc;
        tick();
        cg(nx(v, 0), "run after load");
        present <= 1'b0;
        repeat (2) @(posedge pclk);
        apb(0, OFS_RX, 0);
        chk(q, 32'hffff_ffff, "rx dashes");
        chk(32'(rx_code_valid), 0, "rx invalid");
        // flywheel on loss, single rejam on reconnect, daily seed from reset
        apb(1, OFS_CTRL, 32'h26);
        v = gen_tc;
        tick();
        cg(nx(v, 0), "flywheel");
        apb(1, OFS_CTRL, 32'h23);
        present <= 1'b1;
        frm(1);
        cg(rx_tc, "rejam");
        v = rx_tc;
        frm(1);
        cg(v, "no second rejam");
        apb(1, OFS_CTRL, 32'h24);
        tick();
        cg(tod, "daily seed");
        $display("test receive done");
        // auto-record with a one-tenth hold-off, pre-roll on
        apb(1, OFS_HOLD, 32'h1);
        apb(1, OFS_CTRL, 32'ha7);
        present <= 1'b1;
        frm(0);
        adv <= 1'b1;
        send <= 1'b1;
        @(posedge pclk);
        send <= 1'b0;
        for (n = 0; n < 10 && rec_pending !== 1'b1; n++) @(posedge pclk);
        chk(32'(preroll_capture), 1, "preroll at detect");
        for (n = 0; n < 20 && rec_request !== 1'b1; n++) @(posedge pclk);
        chk(32'(n), 32'(TC + 1), "holdoff cycles");
        chk(32'({file_open, fs.ff}), 32'h20, "file start");
        frm(0);
        chk(32'(rec_request), 0, "stationary stop");
        $display("test capture done");
        // user-bit formats and generator off
        for (i = 0; i < 7; i++) begin
            apb(1, OFS_CTRL, 32'h22 | (i << 8));
            apb(1, OFS_UBITS, 32'h1234);
            chk(32'(e), 32'(i >= 4), "ubits edit");
        end
        chk(32'(lock), 1, "locked flag");
        chk(ubits, 32'h1234, "user bits kept");
        apb(1, OFS_CTRL, 32'h20);
        v = gen_tc;
        tick();
        chk(32'({gen_blank, w(gen_tc) == w(v)}), 32'h3, "off");
        $display("test formats done");
        wrap_up();
    end
endmodule
`default_nettype wire
